// >>> hw/ucbrp_params.svh
// offsets, field positions, reset values and timing counts
`ifndef UCBRP_PARAMS_SVH
`define UCBRP_PARAMS_SVH
// register indices; byte address is four times the index
`define UCBRP_IDX_CFG 8'h9D
`define UCBRP_IDX_DATA 8'h9F
`define UCBRP_IDX_ADDR_LO 8'hA1
`define UCBRP_IDX_ADDR_HI 8'hA2
`define UCBRP_CFG_RESET 8'h00
// utility configuration fields
`define UCBRP_BIT_CODE_SEL 7
`define UCBRP_BIT_RSVD 6
`define UCBRP_BIT_BLINK 5
`define UCBRP_BIT_PIN4 4
`define UCBRP_BIT_T1 3
`define UCBRP_BIT_T0 2
`define UCBRP_BIT_TX 1
`define UCBRP_BIT_RX 0
`define UCBRP_ADDR_HI_W 3
// scratch window
`define UCBRP_SCRATCH_LO 16'h0400
`define UCBRP_SCRATCH_HI 16'h06FF
// blink period in ms, clock period in ns
`define UCBRP_BLINK_PERIOD_MS 1000
`define UCBRP_CLK_PERIOD_NS 5
`define UCBRP_BLINK_HALF_CYC ((`UCBRP_BLINK_PERIOD_MS * 1000000 / 2) / `UCBRP_CLK_PERIOD_NS)
`endif

// >>> hw/ucbrp_pkg.sv
// types shared by the config register and buffer ram port
package ucbrp_pkg;
	typedef logic [7:0] ucbrp_byte_t;
	typedef enum logic [2:0]
	{
		UCBRP_SEL_NONE = 3'b000,
		UCBRP_SEL_CFG = 3'b001,
		UCBRP_SEL_DATA = 3'b010,
		UCBRP_SEL_ADDR_LO = 3'b011,
		UCBRP_SEL_ADDR_HI = 3'b100
	} ucbrp_sel_e;
endpackage

// >>> hw/ucbrp_top.sv
// utility configuration register and buffer ram data port, apb slave
// Function
// - code-space select bit maps 768-byte scratch ram into code space, else data space
// - auto blink on pin 0, one second period, half duty, when output
// - bit 4 selects general output or ata write strobe on pin 4
// - bit 3 selects timer 1 input source, 0 gives pin 3
// - bit 2 selects timer 0 input source, 0 gives pin 2
// - bit 1 selects general output or serial transmit on pin 1
// - bit 0 feeds serial receive from pin 0, or forces zero
// - data port write stores byte at current buffer address
// - data port read returns byte at current buffer address
// - low address register holds address bits 7 to 0, read/write
// - high address register bits 2 to 0 hold address bits 10 to 8
// - high address register bits 7 to 3 read zero, writes ignored
// - every data port access increments the buffer address
// - auto-incrementing data accesses work back to back
`include "ucbrp_params.svh"

module ucbrp_top #(
	parameter int unsigned ADDR_W = 11,
	parameter int unsigned PADDR_W = 12,
	parameter int unsigned BLINK_HALF_CYC = `UCBRP_BLINK_HALF_CYC
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [PADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [15:0] i_code_addr,
	input wire logic [15:0] i_xdata_addr,
	output logic o_scratch_code_hit,
	output logic o_scratch_xdata_hit,
	input wire ucbrp_pkg::ucbrp_byte_t i_gpio_out,
	input wire logic i_pin0_dir_out,
	input wire logic [3:0] i_gpio_in,
	input wire logic i_ata_io_write_strobe,
	input wire logic i_mcu_serial_tx_line,
	input wire logic i_timer0_alt_src,
	input wire logic i_timer1_alt_src,
	output logic o_pin0_out,
	output logic o_pin1_out,
	output logic o_pin4_out,
	output logic o_mcu_timer0_input_line,
	output logic o_mcu_timer1_input_line,
	output logic o_mcu_serial_rx_line
);
	import ucbrp_pkg::*;

	localparam int unsigned CNT_W = $clog2(BLINK_HALF_CYC + 1);
	localparam int unsigned DEPTH = 2 ** ADDR_W;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function automatic ucbrp_sel_e decode(input logic [PADDR_W-1:0] addr);
		ucbrp_sel_e sel;
		sel = UCBRP_SEL_NONE;
		case (addr)
			PADDR_W'({`UCBRP_IDX_CFG, 2'b00}): sel = UCBRP_SEL_CFG;
			PADDR_W'({`UCBRP_IDX_DATA, 2'b00}): sel = UCBRP_SEL_DATA;
			PADDR_W'({`UCBRP_IDX_ADDR_LO, 2'b00}): sel = UCBRP_SEL_ADDR_LO;
			PADDR_W'({`UCBRP_IDX_ADDR_HI, 2'b00}): sel = UCBRP_SEL_ADDR_HI;
			default: sel = UCBRP_SEL_NONE;
		endcase
		return sel;
	endfunction

	function automatic logic in_scratch(input logic [15:0] addr);
		return (addr >= `UCBRP_SCRATCH_LO) && (addr <= `UCBRP_SCRATCH_HI);
	endfunction

	ucbrp_sel_e sel;
	logic setup;
	logic access;
	logic wr_en;
	logic data_acc;
	ucbrp_byte_t cfg_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] addr_next;
	ucbrp_byte_t mem [DEPTH];
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic [CNT_W-1:0] blink_cnt_reg;
	logic blink_reg;
	logic blink_on;

	assign sel = decode(i_paddr);
	assign setup = i_psel && !i_penable;
	assign access = i_psel && i_penable;
	assign wr_en = access && i_pwrite && i_pstrb[0];
	assign data_acc = access && (sel == UCBRP_SEL_DATA);

	// zero wait states; unmapped addresses answer with an error
	assign o_pready = 1'b1;
	assign o_pslverr = access && (sel == UCBRP_SEL_NONE);
	assign o_prdata = prdata_reg;

	// ----------------------------------------
	// utility configuration register
	// ----------------------------------------
	// reserved bit 6 is stored like the rest; firmware keeps it clear
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			cfg_reg <= `UCBRP_CFG_RESET;
		else if (wr_en && sel == UCBRP_SEL_CFG)
			cfg_reg <= i_pwdata[7:0];
	end

	// ----------------------------------------
	// buffer address pair
	// ----------------------------------------
	always_comb
	begin
		addr_next = addr_reg;
		if (wr_en && sel == UCBRP_SEL_ADDR_LO)
			addr_next[7:0] = i_pwdata[7:0];
		else if (wr_en && sel == UCBRP_SEL_ADDR_HI)
			addr_next[ADDR_W-1:8] = i_pwdata[ADDR_W-9:0];
		else if (data_acc)
			addr_next = addr_reg + ADDR_W'(1);
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			addr_reg <= '0;
		else
			addr_reg <= addr_next;
	end

	// ----------------------------------------
	// buffer ram
	// ----------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (wr_en && sel == UCBRP_SEL_DATA)
			mem[addr_reg] <= i_pwdata[7:0];
	end

	// ----------------------------------------
	// read data, captured in the setup cycle
	// ----------------------------------------
	always_comb
	begin
		prdata_next = '0;
		case (sel)
			UCBRP_SEL_CFG: prdata_next[7:0] = cfg_reg;
			UCBRP_SEL_DATA: prdata_next[7:0] = mem[addr_reg];
			UCBRP_SEL_ADDR_LO: prdata_next[7:0] = addr_reg[7:0];
			UCBRP_SEL_ADDR_HI: prdata_next[ADDR_W-9:0] = addr_reg[ADDR_W-1:8];
			default: prdata_next = '0;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			prdata_reg <= '0;
		else if (setup && !i_pwrite)
			prdata_reg <= prdata_next;
	end

	// ----------------------------------------
	// scratch ram placement
	// ----------------------------------------
	assign o_scratch_code_hit = cfg_reg[`UCBRP_BIT_CODE_SEL] && in_scratch(i_code_addr);
	assign o_scratch_xdata_hit = !cfg_reg[`UCBRP_BIT_CODE_SEL] && in_scratch(i_xdata_addr);

	// ----------------------------------------
	// pin 0 auto blink
	// ----------------------------------------
	assign blink_on = cfg_reg[`UCBRP_BIT_BLINK] && i_pin0_dir_out;

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			blink_cnt_reg <= '0;
		else if (!blink_on || blink_cnt_reg == CNT_W'(BLINK_HALF_CYC - 1))
			blink_cnt_reg <= '0;
		else
			blink_cnt_reg <= blink_cnt_reg + CNT_W'(1);
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			blink_reg <= 1'b0;
		else if (!blink_on)
			blink_reg <= 1'b0;
		else if (blink_cnt_reg == CNT_W'(BLINK_HALF_CYC - 1))
			blink_reg <= !blink_reg;
	end

	// ----------------------------------------
	// pin function muxes
	// ----------------------------------------
	assign o_pin0_out = blink_on ? blink_reg : i_gpio_out[0];
	assign o_pin1_out = cfg_reg[`UCBRP_BIT_TX] ? i_mcu_serial_tx_line : i_gpio_out[1];
	assign o_pin4_out = cfg_reg[`UCBRP_BIT_PIN4] ? i_ata_io_write_strobe : i_gpio_out[4];
	assign o_mcu_timer1_input_line = cfg_reg[`UCBRP_BIT_T1] ? i_timer1_alt_src : i_gpio_in[3];
	assign o_mcu_timer0_input_line = cfg_reg[`UCBRP_BIT_T0] ? i_timer0_alt_src : i_gpio_in[2];
	assign o_mcu_serial_rx_line = cfg_reg[`UCBRP_BIT_RX] ? 1'b0 : i_gpio_in[0];

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);

	sequence s_cfg_wr;
		wr_en && sel == UCBRP_SEL_CFG;
	endsequence

	sequence s_data_wr;
		wr_en && sel == UCBRP_SEL_DATA;
	endsequence

	sequence s_data_rd_setup;
		setup && !i_pwrite && sel == UCBRP_SEL_DATA;
	endsequence

	sequence s_data_rd_acc;
		data_acc && !i_pwrite;
	endsequence

	sequence s_addr_lo_wr;
		wr_en && sel == UCBRP_SEL_ADDR_LO;
	endsequence

	sequence s_addr_hi_wr;
		wr_en && sel == UCBRP_SEL_ADDR_HI;
	endsequence

	sequence s_data_b2b;
		s_data_wr ##2 s_data_wr;
	endsequence

	AST_CODE_MAP: assert property (
		s_cfg_wr ##1 in_scratch(i_code_addr)
		|-> o_scratch_code_hit == $past(i_pwdata[`UCBRP_BIT_CODE_SEL]))
		else $error("scratch code mapping does not follow config bit");

	AST_BLINK_TOGGLE: assert property (
		blink_on && blink_cnt_reg == CNT_W'(BLINK_HALF_CYC - 1) && $past(blink_on)
		|=> blink_reg != $past(blink_reg))
		else $error("pin 0 blink did not toggle at half period");

	AST_BLINK_HOLD: assert property (
		blink_on && blink_cnt_reg != CNT_W'(BLINK_HALF_CYC - 1)
		##1 blink_on |-> $stable(blink_reg))
		else $error("pin 0 blink toggled early");

	AST_PIN4_MUX: assert property (
		s_cfg_wr ##1 1'b1 |-> o_pin4_out ==
		($past(i_pwdata[`UCBRP_BIT_PIN4]) ? i_ata_io_write_strobe : i_gpio_out[4]))
		else $error("pin 4 source wrong");

	AST_T1_SRC: assert property (
		!cfg_reg[`UCBRP_BIT_T1] |-> o_mcu_timer1_input_line == i_gpio_in[3])
		else $error("timer 1 input not from pin 3");

	AST_T0_SRC: assert property (
		!cfg_reg[`UCBRP_BIT_T0] |-> o_mcu_timer0_input_line == i_gpio_in[2])
		else $error("timer 0 input not from pin 2");

	AST_TX_MUX: assert property (
		s_cfg_wr ##1 $past(i_pwdata[`UCBRP_BIT_TX])
		|-> o_pin1_out == i_mcu_serial_tx_line)
		else $error("pin 1 not driven by serial transmit");

	AST_RX_FORCE: assert property (
		s_cfg_wr ##1 $past(i_pwdata[`UCBRP_BIT_RX]) |-> !o_mcu_serial_rx_line)
		else $error("serial receive not forced low");

	AST_DATA_STORE: assert property (
		s_data_wr |=> mem[$past(addr_reg)] == $past(i_pwdata[7:0]))
		else $error("data port write not stored");

	AST_DATA_READ: assert property (
		s_data_rd_setup |=> o_prdata == {24'h000000, mem[$past(addr_reg)]})
		else $error("data port read wrong byte");

	AST_HI_RSVD: assert property (
		setup && !i_pwrite && sel == UCBRP_SEL_ADDR_HI |=> o_prdata[31:3] == 29'h00000000)
		else $error("high address reserved bits not zero");

	AST_INCREMENT: assert property (
		data_acc |=> addr_reg == ADDR_W'($past(addr_reg) + ADDR_W'(1)))
		else $error("buffer address did not increment");

	AST_BACK_TO_BACK: assert property (
		s_data_b2b |=> addr_reg == ADDR_W'($past(addr_reg, 3) + ADDR_W'(2)))
		else $error("back to back accesses lost an increment");

	AST_B2B_READ: assert property (
		s_data_rd_acc ##2 s_data_rd_acc
		|=> addr_reg == ADDR_W'($past(addr_reg, 3) + ADDR_W'(2)))
		else $error("back to back reads lost an increment");

	AST_ADDR_LO_LOAD: assert property (
		s_addr_lo_wr |=> addr_reg[7:0] == $past(i_pwdata[7:0])
		&& addr_reg[ADDR_W-1:8] == $past(addr_reg[ADDR_W-1:8]))
		else $error("low address register not loaded");

	AST_ADDR_HI_LOAD: assert property (
		s_addr_hi_wr |=> addr_reg[ADDR_W-1:8] == $past(i_pwdata[ADDR_W-9:0])
		&& addr_reg[7:0] == $past(addr_reg[7:0]))
		else $error("high address register not loaded");

	AST_CODE_WINDOW: assert property (
		cfg_reg[`UCBRP_BIT_CODE_SEL] |-> !o_scratch_xdata_hit && o_scratch_code_hit ==
		(i_code_addr >= `UCBRP_SCRATCH_LO && i_code_addr <= `UCBRP_SCRATCH_HI))
		else $error("scratch ram not placed in code space");

	AST_XDATA_WINDOW: assert property (
		!cfg_reg[`UCBRP_BIT_CODE_SEL] |-> !o_scratch_code_hit && o_scratch_xdata_hit ==
		(i_xdata_addr >= `UCBRP_SCRATCH_LO && i_xdata_addr <= `UCBRP_SCRATCH_HI))
		else $error("scratch ram not placed in data space");

	AST_PIN0_PLAIN: assert property (
		!blink_on |-> o_pin0_out == i_gpio_out[0])
		else $error("pin 0 not general output while blink off");

	AST_PIN0_BLINK: assert property (
		blink_on |-> o_pin0_out == blink_reg)
		else $error("pin 0 not driven by blink");

	AST_BLINK_OFF: assert property (
		!blink_on |=> blink_reg == 1'b0 && blink_cnt_reg == '0)
		else $error("blink state not cleared when disabled");

	AST_TX_PLAIN: assert property (
		!cfg_reg[`UCBRP_BIT_TX] |-> o_pin1_out == i_gpio_out[1])
		else $error("pin 1 not general output");

	AST_RX_PIN: assert property (
		!cfg_reg[`UCBRP_BIT_RX] |-> o_mcu_serial_rx_line == i_gpio_in[0])
		else $error("serial receive not fed from pin 0");

endmodule // ucbrp_top

// >>> tb/ucbrp_core_model.sv
// firmware-side apb master standing in for the microcontroller core
`include "ucbrp_params.svh"

module ucbrp_core_model (
	input wire logic i_clk,
	input wire logic i_pready,
	input wire logic [31:0] i_prdata,
	output logic o_psel,
	output logic o_penable,
	output logic o_pwrite,
	output logic [11:0] o_paddr,
	output logic [31:0] o_pwdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 12'h000;
		o_pwdata = 32'h0000_0000;
	end
	// ----------------------------------------
	// one apb transfer, held until pready
	// ----------------------------------------
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d,
		input logic last, output logic [31:0] q);
		o_psel <= 1'b1;
		o_pwrite <= wr;
		o_paddr <= {2'h0, idx, 2'h0};
		o_pwdata <= {24'h0, (idx == `UCBRP_IDX_CFG) ? (d & 8'hBF) : d};
		@(posedge i_clk);
		o_penable <= 1'b1;
		do
			@(posedge i_clk);
		while (i_pready !== 1'b1);
		q = i_prdata;
		o_penable <= 1'b0;
		// psel stays up when the next setup follows at once
		if (last)
			o_psel <= 1'b0;
	endtask
endmodule // ucbrp_core_model

// >>> tb/testbench.sv
// self-checking bench for the config register and buffer ram port
`include "ucbrp_params.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import ucbrp_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel, pen, pwr, pready, serr, serr_q = 1'b0, hold = 1'b0, chk = 1'b0;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] caddr = 16'h0000, xaddr = 16'h0000;
	ucbrp_byte_t gout = 8'h00;
	logic dir = 1'b0, stb = 1'b0, tx = 1'b0, a0 = 1'b0, a1 = 1'b0;
	logic [3:0] gin = 4'h0;
	logic p0, p1, p4, t0, t1, rx, ch, xh;
	logic [7:0] cfg_m = 8'h00, d;
	logic [10:0] a;
	logic [10:0] base_t [2] = '{11'h0FE, 11'h7FD};
	ucbrp_byte_t mem_m [2048];
	int fail_count = 0, n_compared = 0, cyc = 0;

	always #2.5 clk = ~clk;

	ucbrp_core_model core (.i_clk(clk), .i_pready(pready), .i_prdata(prdata), .o_psel(psel),
		.o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata));

	ucbrp_top #(.BLINK_HALF_CYC(8)) uut (.i_clk(clk), .i_nrst(nrst), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(serr), .i_code_addr(caddr),
		.i_xdata_addr(xaddr), .o_scratch_code_hit(ch), .o_scratch_xdata_hit(xh),
		.i_gpio_out(gout), .i_pin0_dir_out(dir), .i_gpio_in(gin), .i_ata_io_write_strobe(stb),
		.i_mcu_serial_tx_line(tx), .i_timer0_alt_src(a0), .i_timer1_alt_src(a1),
		.o_pin0_out(p0), .o_pin1_out(p1), .o_pin4_out(p4), .o_mcu_timer0_input_line(t0),
		.o_mcu_timer1_input_line(t1), .o_mcu_serial_rx_line(rx));
	// ----------------------------------------
	// tasks and expectations
	// ----------------------------------------
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		core.xfer(1'b1, idx, v, 1'b1, q);
		if (idx == `UCBRP_IDX_CFG)
			cfg_m = v & 8'hBF;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] idx);
		core.xfer(1'b0, idx, 8'h00, 1'b1, q);
		@(posedge clk);
	endtask

	function automatic logic inr(input logic [15:0] x);
		return x >= `UCBRP_SCRATCH_LO && x <= `UCBRP_SCRATCH_HI;
	endfunction

	function automatic logic [7:0] exp_pins();
		return {cfg_m[7] & inr(caddr), !cfg_m[7] & inr(xaddr), cfg_m[4] ? stb : gout[4],
			cfg_m[1] ? tx : gout[1], cfg_m[3] ? a1 : gin[3], cfg_m[2] ? a0 : gin[2],
			!cfg_m[0] & gin[0], (cfg_m[5] & dir) ? 1'b0 : gout[0]};
	endfunction

	always @(negedge clk)
		if (chk)
			cmp(32'({ch, xh, p4, p1, t1, t0, rx, (cfg_m[5] & dir) ? 1'b0 : p0}),
				32'(exp_pins()));

	always @(posedge clk)
		if (psel && pen)
			serr_q <= serr;

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			print_verdict();
		end
	end
	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial
	begin
		void'($urandom(32'hED9A));
		fork
			forever
			begin
				@(posedge clk);
				caddr <= 16'h0380 + 16'($urandom_range(0, 16'h3FF));
				xaddr <= 16'h0380 + 16'($urandom_range(0, 16'h3FF));
				if (!hold)
					{dir, gout, gin, stb, tx, a0, a1} <= 17'($urandom);
			end
		join_none
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk = 1'b1;
		rd(`UCBRP_IDX_CFG);
		cmp(q, 32'h0);
		for (int i = 0; i < 10; i++)
		begin
			d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
			wr(`UCBRP_IDX_CFG, d);
			rd(`UCBRP_IDX_CFG);
			cmp(q, {24'h0, d & 8'hBF});
		end
		wr(`UCBRP_IDX_ADDR_HI, 8'hFF);
		rd(`UCBRP_IDX_ADDR_HI);
		cmp(q, 32'h7);
		d = 8'($urandom);
		wr(`UCBRP_IDX_ADDR_LO, d);
		rd(`UCBRP_IDX_ADDR_LO);
		cmp(q, {24'h0, d});
		foreach (base_t[j])
		begin
			wr(`UCBRP_IDX_ADDR_HI, {5'h0, base_t[j][10:8]});
			wr(`UCBRP_IDX_ADDR_LO, base_t[j][7:0]);
			for (int k = 0; k < 6; k++)
			begin
				d = 8'($urandom);
				mem_m[base_t[j] + 11'(k)] = d;
				core.xfer(1'b1, `UCBRP_IDX_DATA, d, k == 5, q);
			end
			@(posedge clk);
			rd(`UCBRP_IDX_ADDR_LO);
			a[7:0] = q[7:0];
			rd(`UCBRP_IDX_ADDR_HI);
			a[10:8] = q[2:0];
			cmp(32'(a), 32'(11'(base_t[j] + 11'd6)));
			wr(`UCBRP_IDX_ADDR_HI, {5'h0, base_t[j][10:8]});
			wr(`UCBRP_IDX_ADDR_LO, base_t[j][7:0]);
			for (int k = 0; k < 6; k++)
			begin
				core.xfer(1'b0, `UCBRP_IDX_DATA, 8'h00, k == 5, q);
				cmp(q, {24'h0, mem_m[base_t[j] + 11'(k)]});
			end
			@(posedge clk);
		end
		wr(8'h9E, 8'hFF);
		cmp(32'(serr_q), 32'h1);
		rd(`UCBRP_IDX_CFG);
		cmp(q, {24'h0, cfg_m});
		cmp(32'(serr_q), 32'h0);
		nrst <= 1'b0;
		cfg_m = 8'h00;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd(`UCBRP_IDX_CFG);
		cmp(q, 32'h0);
		rd(`UCBRP_IDX_ADDR_HI);
		cmp(q, 32'h0);
		rd(`UCBRP_IDX_ADDR_LO);
		cmp(q, 32'h0);
		hold = 1'b1;
		wr(`UCBRP_IDX_CFG, 8'h00);
		dir <= 1'b1;
		@(posedge clk);
		wr(`UCBRP_IDX_CFG, 8'h20);
		for (int k = 1; k < 24; k++)
		begin
			@(negedge clk);
			cmp(32'(p0), 32'(k >= 8 && k < 16));
		end
		print_verdict();
	end
endmodule // testbench
